// ==== inc/ssr_map.svh ====
// bit positions, masks, reset values and limits of the status block
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH

// standard event bit positions
`define SSR_ESR_OPC 0
`define SSR_ESR_QUERY 2
`define SSR_ESR_DEVICE 3
`define SSR_ESR_EXEC 4
`define SSR_ESR_CMD 5
`define SSR_ESR_PON 7
`define SSR_ESR_RST 8'h80
`define SSR_ESR_USED 8'hbd

// summary byte bit positions
`define SSR_STB_ERRQ 2
`define SSR_STB_QUES 3
`define SSR_STB_MAV 4
`define SSR_STB_ESB 5
`define SSR_STB_MSS 6
`define SSR_STB_SRC 8'h3c
`define SSR_STB_USED 8'h7c
`define SSR_SRE_USED 8'hbf

// questionable group implemented bits
`define SSR_QUES_USED 16'h1e2f

`define SSR_BYTE_ZERO 8'h00
`define SSR_WORD_ZERO 16'h0000

// error code class limits, signed 16 bit
`define SSR_ERR_QRY_LO 16'shfe0d
`define SSR_ERR_QRY_HI 16'shfe70
`define SSR_ERR_DEV_LO 16'shfe71
`define SSR_ERR_DEV_HI 16'shfed4
`define SSR_ERR_EXE_LO 16'shfed5
`define SSR_ERR_EXE_HI 16'shff38
`define SSR_ERR_CMD_LO 16'shff39
`define SSR_ERR_CMD_HI 16'shff9c
`define SSR_ERR_POS_MIN 16'sh0001

// error queue geometry
`define SSR_ERRQ_DEPTH 4'h8
`define SSR_ERRQ_PTR_ONE 3'h1
`define SSR_ERRQ_CNT_ONE 4'h1
`define SSR_ERR_NONE 16'h0000

`endif

// ==== inc/ssr_pkg.sv ====
// types shared by the status reporting block
package ssr_pkg;
   typedef logic [7:0] ssr_byte_t;
   typedef logic [15:0] ssr_word_t;
   typedef logic [2:0] ssr_ptr_t;
   typedef logic [3:0] ssr_cnt_t;
   typedef enum logic [1:0] {
      SSR_CLR_IDLE,
      SSR_CLR_ABORT,
      SSR_CLR_FLUSH
   } ssr_clr_state_t;
endpackage

// ==== core/ssr_errq.sv ====
// error queue memory with registered read data
`include "ssr_map.svh"
module ssr_errq (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic push_i,
   input wire ssr_pkg::ssr_word_t data_i,
   input wire logic pop_i,
   input wire logic clear_i,
   output ssr_pkg::ssr_word_t rd_data_o,
   output logic empty_o
);
   ssr_pkg::ssr_word_t mem [0:7];
   ssr_pkg::ssr_ptr_t wptr_reg;
   ssr_pkg::ssr_ptr_t rptr_reg;
   ssr_pkg::ssr_cnt_t cnt_reg;
   ssr_pkg::ssr_cnt_t cnt_next;
   ssr_pkg::ssr_word_t rd_reg;
   logic do_pop;
   logic do_push;
   ssr_pkg::ssr_ptr_t wr_addr;

   // a full queue drops the newest error unless a pop makes room
   assign empty_o = (cnt_reg == 4'h0);
   assign do_pop = pop_i && !empty_o && !clear_i;
   // an error raised in a clear cycle lands in the emptied queue
   assign do_push = push_i &&
      (clear_i || (cnt_reg != `SSR_ERRQ_DEPTH) || do_pop);
   assign wr_addr = clear_i ? 3'h0 : wptr_reg;
   assign cnt_next = cnt_reg + (do_push ? `SSR_ERRQ_CNT_ONE : 4'h0)
      - (do_pop ? `SSR_ERRQ_CNT_ONE : 4'h0);
   assign rd_data_o = rd_reg;

   // storage needs no reset, pointers do
   always_ff @(posedge clk_sys_i) begin
      if (ce_i && do_push) begin
         mem[wr_addr] <= data_i;
      end
   end

   // pointers, count and read data register
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         wptr_reg <= 3'h0;
         rptr_reg <= 3'h0;
         cnt_reg <= 4'h0;
         rd_reg <= `SSR_ERR_NONE;
      end else if (ce_i) begin
         if (clear_i) begin
            wptr_reg <= do_push ? `SSR_ERRQ_PTR_ONE : 3'h0;
            rptr_reg <= 3'h0;
            cnt_reg <= do_push ? `SSR_ERRQ_CNT_ONE : 4'h0;
            rd_reg <= `SSR_ERR_NONE;
         end else begin
            if (do_push) begin
               wptr_reg <= wptr_reg + `SSR_ERRQ_PTR_ONE;
            end
            if (do_pop) begin
               rptr_reg <= rptr_reg + `SSR_ERRQ_PTR_ONE;
            end
            if (pop_i) begin
               rd_reg <= empty_o ? `SSR_ERR_NONE : mem[rptr_reg];
            end
            cnt_reg <= cnt_next;
         end
      end
   end
endmodule

// ==== core/ssr_status.sv ====
// status byte, standard event and questionable groups with device clear
`include "ssr_map.svh"
// What this block does
// RQ1: condition register tracks live state, read-only; reads never clear it.
// RQ2: event bits latch changes; repeat events on a set bit are ignored.
// RQ3: event bit stays set until its query read or a clear status.
// RQ4: read/write enable mask picks event bits feeding the group summary.
// RQ5: group summary is OR of event AND enable.
// RQ6: bit 0 sets when commands through operation complete finish; 1,6 zero.
// RQ7: query, device, execution and command errors set bits 2,3,4,5.
// RQ8: bit 7 flags power cycled since last read or clear.
// RQ9: standard event register clears on clear status or its query read.
// RQ10: standard event mask loads from the written value; zero clears it.
// RQ11: summary bit 4 shows output data waiting, without extra delay.
// RQ12: summary bit 2 shows a non-empty error queue; error reads pop it.
// RQ13: summary bit 3 is the enabled questionable event summary.
// RQ14: summary bit 5 is the enabled standard event summary.
// RQ15: bit 6 sums enabled summary bits, may request service; 0,1,7 zero.
// RQ16: clearing a group event register clears only its summary bit.
// RQ17: clear status empties the whole summary byte.
// RQ18: writing zero to the summary enable mask clears it.
// RQ19: device clear stops measuring, idles trigger, flushes buffers, readies.
// RQ20: device clear leaves status, error queue and settings untouched.
// RQ21: device clear ends overlapped command without operation complete.
// RQ22: controller waits about two seconds after device clear.
module ssr_status (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic cls_i,
   input wire logic esr_rd_i,
   input wire logic ese_wr_i,
   input wire ssr_pkg::ssr_byte_t ese_val_i,
   input wire logic sre_wr_i,
   input wire ssr_pkg::ssr_byte_t sre_val_i,
   input wire ssr_pkg::ssr_word_t ques_cond_i,
   input wire logic ques_rd_i,
   input wire logic ques_ena_wr_i,
   input wire ssr_pkg::ssr_word_t ques_ena_val_i,
   input wire logic opc_cmd_i,
   input wire logic ovl_busy_i,
   input wire logic err_valid_i,
   input wire ssr_pkg::ssr_word_t err_code_i,
   input wire logic err_pop_i,
   input wire logic mav_i,
   input wire logic dcl_i,
   output ssr_pkg::ssr_byte_t esr_o,
   output ssr_pkg::ssr_byte_t ese_o,
   output ssr_pkg::ssr_byte_t sre_o,
   output ssr_pkg::ssr_byte_t stb_o,
   output logic srq_o,
   output ssr_pkg::ssr_word_t ques_cond_o,
   output ssr_pkg::ssr_word_t ques_evt_o,
   output ssr_pkg::ssr_word_t ques_ena_o,
   output ssr_pkg::ssr_word_t err_code_o,
   output logic abort_meas_o,
   output logic trig_idle_o,
   output logic flush_buf_o,
   output logic cmd_ready_o
);
   ssr_pkg::ssr_byte_t esr_reg;
   ssr_pkg::ssr_byte_t esr_next;
   ssr_pkg::ssr_byte_t esr_set;
   ssr_pkg::ssr_byte_t esr_rd_reg;
   ssr_pkg::ssr_byte_t ese_reg;
   ssr_pkg::ssr_byte_t sre_reg;
   ssr_pkg::ssr_byte_t stb_reg;
   ssr_pkg::ssr_byte_t stb_src;
   ssr_pkg::ssr_byte_t stb_next;
   ssr_pkg::ssr_word_t ques_cond_reg;
   ssr_pkg::ssr_word_t ques_prev_reg;
   ssr_pkg::ssr_word_t ques_evt_reg;
   ssr_pkg::ssr_word_t ques_evt_next;
   ssr_pkg::ssr_word_t ques_rd_reg;
   ssr_pkg::ssr_word_t ques_ena_reg;
   ssr_pkg::ssr_word_t ques_live;
   ssr_pkg::ssr_clr_state_t clr_state_reg;
   ssr_pkg::ssr_clr_state_t clr_state_next;
   logic opc_pend_reg;
   logic opc_pend_next;
   logic opc_fire;
   logic err_qry;
   logic err_dev;
   logic err_exe;
   logic err_cmd;
   logic ques_sum;
   logic esb_sum;
   logic mss_sum;
   logic errq_empty;
   logic abort_reg;
   logic idle_reg;
   logic flush_reg;
   logic ready_reg;

   // every check below runs on the system clock and sleeps in reset
   default clocking cb_sys @(posedge clk_sys_i);
   endclocking
   default disable iff (!nrst_i);

   // error queue; device clear is not wired to it on purpose
   ssr_errq u_errq (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .push_i(err_valid_i),
      .data_i(err_code_i),
      .pop_i(err_pop_i),
      .clear_i(cls_i),
      .rd_data_o(err_code_o),
      .empty_o(errq_empty)
   ); // RQ12 RQ20

   // error class decode on the signed code
   assign err_qry = err_valid_i &&
      ($signed(err_code_i) >= `SSR_ERR_QRY_LO) &&
      ($signed(err_code_i) <= `SSR_ERR_QRY_HI); // RQ7
   assign err_dev = err_valid_i &&
      ((($signed(err_code_i) >= `SSR_ERR_DEV_LO) &&
      ($signed(err_code_i) <= `SSR_ERR_DEV_HI)) ||
      ($signed(err_code_i) >= `SSR_ERR_POS_MIN)); // RQ7
   assign err_exe = err_valid_i &&
      ($signed(err_code_i) >= `SSR_ERR_EXE_LO) &&
      ($signed(err_code_i) <= `SSR_ERR_EXE_HI); // RQ7
   assign err_cmd = err_valid_i &&
      ($signed(err_code_i) >= `SSR_ERR_CMD_LO) &&
      ($signed(err_code_i) <= `SSR_ERR_CMD_HI); // RQ7

   // completion fires only once no overlapped work remains
   // a device clear cancels the pending mark so no completion is flagged
   assign opc_fire = opc_pend_reg && !ovl_busy_i && !dcl_i; // RQ6 RQ21
   assign opc_pend_next = dcl_i ? 1'b0 :
      (opc_cmd_i || (opc_pend_reg && !opc_fire)); // RQ21

   // standard event sets; unused bits 1 and 6 never set
   assign esr_set = {1'b0, 1'b0, err_cmd, err_exe, err_dev, err_qry,
      1'b0, opc_fire}; // RQ6 RQ7
   // a set in the clear cycle survives: the set is ORed after the clear
   assign esr_next = ((esr_rd_i || cls_i) ? `SSR_BYTE_ZERO : esr_reg)
      | esr_set; // RQ2 RQ3 RQ9

   // questionable condition is the live level, masked to used bits
   assign ques_live = ques_cond_i & `SSR_QUES_USED; // RQ1

   // per bit: a rising condition latches, held until read or clear
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_ques
         assign ques_evt_next[gi] =
            (ques_live[gi] && !ques_prev_reg[gi]) ||
            (ques_evt_reg[gi] && !ques_rd_i && !cls_i); // RQ2 RQ3
      end
   endgenerate

   // group summaries and master summary
   assign ques_sum = |(ques_evt_reg & ques_ena_reg); // RQ5 RQ13 RQ16
   assign esb_sum = |(esr_reg & ese_reg); // RQ5 RQ14
   assign stb_src = {1'b0, 1'b0, esb_sum, mav_i, ques_sum, !errq_empty,
      1'b0, 1'b0}; // RQ11 RQ12 RQ13 RQ14
   assign mss_sum = |(stb_src & sre_reg & `SSR_STB_SRC); // RQ15
   // bit 6 never feeds itself; bits 0, 1, 7 stay zero
   assign stb_next = cls_i ? `SSR_BYTE_ZERO :
      (stb_src | {1'b0, mss_sum, 6'h00}); // RQ15 RQ17

   // device clear sequence: abort and idle with flush, then a flush cycle, then ready
   always_comb begin
      clr_state_next = clr_state_reg;
      case (clr_state_reg)
         ssr_pkg::SSR_CLR_IDLE: begin
            if (dcl_i) begin
               clr_state_next = ssr_pkg::SSR_CLR_ABORT;
            end
         end
         ssr_pkg::SSR_CLR_ABORT: begin
            // a repeated clear starts the abort over
            clr_state_next = dcl_i ? ssr_pkg::SSR_CLR_ABORT :
               ssr_pkg::SSR_CLR_FLUSH;
         end
         ssr_pkg::SSR_CLR_FLUSH: begin
            clr_state_next = dcl_i ? ssr_pkg::SSR_CLR_ABORT :
               ssr_pkg::SSR_CLR_IDLE;
         end
         default: begin
            clr_state_next = ssr_pkg::SSR_CLR_IDLE;
         end
      endcase
   end // RQ19

   // standard event group, power-on bit set by reset
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         esr_reg <= `SSR_ESR_RST; // RQ8
         esr_rd_reg <= `SSR_BYTE_ZERO;
         ese_reg <= `SSR_BYTE_ZERO;
         opc_pend_reg <= 1'b0;
      end else if (ce_i) begin
         esr_reg <= esr_next; // RQ9
         if (esr_rd_i) begin
            esr_rd_reg <= esr_reg; // RQ9
         end
         if (ese_wr_i) begin
            ese_reg <= ese_val_i; // RQ4 RQ10
         end
         opc_pend_reg <= opc_pend_next;
      end
   end

   // questionable group registers
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         ques_cond_reg <= `SSR_WORD_ZERO;
         ques_prev_reg <= `SSR_WORD_ZERO;
         ques_evt_reg <= `SSR_WORD_ZERO;
         ques_rd_reg <= `SSR_WORD_ZERO;
         ques_ena_reg <= `SSR_WORD_ZERO;
      end else if (ce_i) begin
         ques_cond_reg <= ques_live; // RQ1
         ques_prev_reg <= ques_live;
         ques_evt_reg <= ques_evt_next;
         if (ques_rd_i) begin
            ques_rd_reg <= ques_evt_reg;
         end
         if (ques_ena_wr_i) begin
            ques_ena_reg <= ques_ena_val_i & `SSR_QUES_USED; // RQ4
         end
      end
   end

   // summary byte and its enable mask
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         stb_reg <= `SSR_BYTE_ZERO;
         sre_reg <= `SSR_BYTE_ZERO;
      end else if (ce_i) begin
         stb_reg <= stb_next; // RQ11 RQ17
         if (sre_wr_i) begin
            sre_reg <= sre_val_i & `SSR_SRE_USED; // RQ18
         end
      end
   end

   // device clear outputs decoded from the next state, so they are flops
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         clr_state_reg <= ssr_pkg::SSR_CLR_IDLE;
         abort_reg <= 1'b0;
         idle_reg <= 1'b0;
         flush_reg <= 1'b0;
         ready_reg <= 1'b0;
      end else if (ce_i) begin
         clr_state_reg <= clr_state_next;
         abort_reg <= (clr_state_next == ssr_pkg::SSR_CLR_ABORT);
         idle_reg <= (clr_state_next == ssr_pkg::SSR_CLR_ABORT);
         flush_reg <= (clr_state_next != ssr_pkg::SSR_CLR_IDLE);
         ready_reg <= (clr_state_next == ssr_pkg::SSR_CLR_IDLE);
      end
   end // RQ19

   assign esr_o = esr_rd_reg;
   assign ese_o = ese_reg;
   assign sre_o = sre_reg;
   assign stb_o = stb_reg;
   assign srq_o = stb_reg[`SSR_STB_MSS];
   assign ques_cond_o = ques_cond_reg;
   assign ques_evt_o = ques_rd_reg;
   assign ques_ena_o = ques_ena_reg;
   assign abort_meas_o = abort_reg;
   assign trig_idle_o = idle_reg;
   assign flush_buf_o = flush_reg;
   assign cmd_ready_o = ready_reg;

   // checks on the registered behaviour
   chk_cond_track: assert property ( // RQ1
      ce_i |=> ques_cond_o == ($past(ques_cond_i) & `SSR_QUES_USED))
      else $error("condition register does not follow live state");

   chk_evt_hold: assert property ( // RQ3
      ce_i && !ques_rd_i && !cls_i |=>
      (ques_evt_reg & $past(ques_evt_reg)) == $past(ques_evt_reg))
      else $error("questionable event bit dropped without a clear");

   chk_esr_clear: assert property ( // RQ9
      ce_i && (esr_rd_i || cls_i) |=> esr_reg == $past(esr_set))
      else $error("standard event register not cleared");

   chk_esr_read: assert property ( // RQ9
      ce_i && esr_rd_i |=> esr_o == $past(esr_reg))
      else $error("standard event read returned wrong value");

   chk_ese_load: assert property ( // RQ10
      ce_i && ese_wr_i |=> ese_o == $past(ese_val_i))
      else $error("event enable mask not loaded");

   chk_mav_bit: assert property ( // RQ11
      ce_i |=> stb_o[`SSR_STB_MAV] == ($past(mav_i) && !$past(cls_i)))
      else $error("message available bit wrong");

   chk_errq_bit: assert property ( // RQ12
      ce_i |=> stb_o[`SSR_STB_ERRQ] ==
      (!$past(errq_empty) && !$past(cls_i)))
      else $error("error queue bit wrong");

   chk_mss_bit: assert property ( // RQ15
      ce_i |=> (stb_o[`SSR_STB_MSS] ==
      |(stb_o & $past(sre_reg) & `SSR_STB_SRC)) &&
      (srq_o == stb_o[`SSR_STB_MSS]))
      else $error("master summary or service request wrong");

   chk_unused_zero: assert property ( // RQ6 RQ15
      ((stb_o & ~`SSR_STB_USED) == `SSR_BYTE_ZERO) &&
      ((esr_reg & ~`SSR_ESR_USED) == `SSR_BYTE_ZERO))
      else $error("unused status bit reads as one");

   chk_opc_dcl: assert property ( // RQ21
      ce_i && dcl_i && !esr_reg[`SSR_ESR_OPC] |=>
      !esr_reg[`SSR_ESR_OPC] ##1 (!esr_reg[`SSR_ESR_OPC] ||
      $past(opc_cmd_i)))
      else $error("completion flagged after device clear");

   chk_dcl_seq: assert property ( // RQ19
      ce_i && dcl_i |=> abort_meas_o && trig_idle_o && flush_buf_o &&
      !cmd_ready_o)
      else $error("device clear sequence not started");

   chk_dcl_keep: assert property ( // RQ20
      ce_i && dcl_i && !ese_wr_i && !sre_wr_i |=>
      ese_o == $past(ese_o) && sre_o == $past(sre_o))
      else $error("device clear changed a setting");

   cov_pon_read: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
      ce_i && esr_rd_i && esr_reg[`SSR_ESR_PON]);
   cov_srq: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
      $rose(srq_o));
   cov_dcl_done: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
      abort_meas_o ##[1:4] cmd_ready_o);
   cov_opc: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
      ce_i && opc_fire);
endmodule

// ==== testbench/ssr_ctl.sv ====
// remote controller model driving command strobes into the status block
module ssr_ctl (
   input wire logic clk_sys_i,
   output logic [9:0] cmd_o,
   output logic [15:0] val_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // quiet period after a device clear, scaled down from seconds
   localparam int DCL_WAIT = 8;

   // idle with no strobe raised
   initial begin
      cmd_o = 10'h000;
      val_o = 16'h0000;
   end

   // one strobe for one cycle, value held alongside it
   task automatic send(input int c, input logic [15:0] v);
      @(posedge clk_sys_i);
      cmd_o <= 10'h001 << c;
      val_o <= v;
      @(posedge clk_sys_i);
      cmd_o <= 10'h000;
      val_o <= ~v; // stale data would hide a missing qualifier
   endtask

   // no traffic while the device finishes its clear
   task automatic quiet();
      repeat (DCL_WAIT) @(posedge clk_sys_i);
   endtask
endmodule

// ==== testbench/tb.sv ====
// self-checking bench for the status reporting block
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int C_CLS = 0;
   localparam int C_ESR = 1;
   localparam int C_ESE = 2;
   localparam int C_SRE = 3;
   localparam int C_QRD = 4;
   localparam int C_QEN = 5;
   localparam int C_OPC = 6;
   localparam int C_POP = 7;
   localparam int C_DCL = 8;
   localparam int C_ERR = 9;
   logic clk_sys_i = 1'b0;
   logic nrst_i = 1'b0;
   logic ce_i = 1'b1;
   logic ovl_busy_i = 1'b0;
   logic mav_i = 1'b0;
   ssr_pkg::ssr_word_t ques_cond_i = 16'h0000;
   logic [9:0] cmd;
   ssr_pkg::ssr_word_t val;
   ssr_pkg::ssr_byte_t esr_o, ese_o, sre_o, stb_o;
   ssr_pkg::ssr_word_t ques_cond_o, ques_evt_o, ques_ena_o, err_code_o;
   logic srq_o, abort_meas_o, trig_idle_o, flush_buf_o, cmd_ready_o;
   int mismatches = 0;
   int checks = 0;
   logic [15:0] codes [5] = '{16'hff8f, 16'hff22, 16'hfea2, 16'hfe66,
                              16'h0005};
   logic [7:0] bits [5] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h08};

   always #2.5 clk_sys_i = ~clk_sys_i;

   ssr_ctl u_ctl (.clk_sys_i(clk_sys_i), .cmd_o(cmd), .val_o(val));

   ssr_status u_dut (
      .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce_i),
      .cls_i(cmd[C_CLS]), .esr_rd_i(cmd[C_ESR]),
      .ese_wr_i(cmd[C_ESE]), .ese_val_i(val[7:0]),
      .sre_wr_i(cmd[C_SRE]), .sre_val_i(val[7:0]),
      .ques_cond_i(ques_cond_i), .ques_rd_i(cmd[C_QRD]),
      .ques_ena_wr_i(cmd[C_QEN]), .ques_ena_val_i(val),
      .opc_cmd_i(cmd[C_OPC]), .ovl_busy_i(ovl_busy_i),
      .err_valid_i(cmd[C_ERR]), .err_code_i(val), .err_pop_i(cmd[C_POP]),
      .mav_i(mav_i), .dcl_i(cmd[C_DCL]), .esr_o(esr_o), .ese_o(ese_o),
      .sre_o(sre_o), .stb_o(stb_o), .srq_o(srq_o),
      .ques_cond_o(ques_cond_o), .ques_evt_o(ques_evt_o),
      .ques_ena_o(ques_ena_o), .err_code_o(err_code_o),
      .abort_meas_o(abort_meas_o), .trig_idle_o(trig_idle_o),
      .flush_buf_o(flush_buf_o), .cmd_ready_o(cmd_ready_o));

   // compare one value, report and count a difference
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                  exp);
      end
   endtask

   // settle past n more edges so registered outputs have landed
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask

   // read the standard event register and compare the captured byte
   task automatic rd_esr(input logic [7:0] exp);
      u_ctl.send(C_ESR, 16'h0000);
      step(0);
      chk(esr_o, exp);
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // a hang is cut short well beyond the expected run of under two hundred cycles
   initial begin
      repeat (4000) @(posedge clk_sys_i);
      mismatches++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      close_out();
   end

   initial begin
      repeat (10) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      step(2);
      chk(stb_o, 8'h00);
      chk(cmd_ready_o, 1'b1);
      rd_esr(8'h80);
      rd_esr(8'h00);
      $display("power-on test done");
      // each error class, held across idle cycles before the read
      for (int i = 0; i < 5; i++) begin
         u_ctl.send(C_ERR, codes[i]);
         step(5);
         chk(stb_o[2], 1'b1);
         rd_esr(bits[i]);
      end
      for (int i = 0; i < 5; i++) begin
         u_ctl.send(C_POP, 16'h0000);
         step(0);
         chk(err_code_o, codes[i]);
      end
      step(2);
      chk(stb_o[2], 1'b0);
      $display("error test done");
      u_ctl.send(C_ESE, 16'h0020);
      u_ctl.send(C_SRE, 16'h0020);
      step(0);
      chk({ese_o, sre_o}, 16'h2020);
      u_ctl.send(C_ERR, 16'hff8f);
      u_ctl.send(C_ERR, 16'hff8f);
      step(2);
      chk(stb_o, 8'h64);
      chk(srq_o, 1'b1);
      u_ctl.send(C_SRE, 16'h00ff);
      mav_i <= 1'b1;
      step(2);
      chk(sre_o, 8'hbf);
      chk(stb_o, 8'h74);
      rd_esr(8'h20);
      step(2);
      chk(stb_o, 8'h54);
      u_ctl.send(C_ESE, 16'h0000);
      u_ctl.send(C_ERR, 16'hff8f);
      step(2);
      chk(ese_o, 8'h00);
      chk(stb_o, 8'h54);
      u_ctl.send(C_SRE, 16'h0000);
      step(2);
      chk({sre_o, 7'h00, srq_o}, 16'h0000);
      chk(stb_o, 8'h14);
      $display("summary test done");
      // device clear keeps status; its pulses follow the fixed walk
      u_ctl.send(C_DCL, 16'h0000);
      step(0);
      chk({abort_meas_o, trig_idle_o, flush_buf_o, cmd_ready_o}, 4'he);
      step(1);
      chk({abort_meas_o, trig_idle_o, flush_buf_o, cmd_ready_o}, 4'h2);
      step(1);
      chk({abort_meas_o, trig_idle_o, flush_buf_o, cmd_ready_o}, 4'h1);
      chk(stb_o, 8'h14);
      u_ctl.quiet();
      rd_esr(8'h20);
      $display("device clear test done");
      u_ctl.send(C_OPC, 16'h0000);
      step(3);
      rd_esr(8'h01);
      @(posedge clk_sys_i);
      ovl_busy_i <= 1'b1;
      u_ctl.send(C_OPC, 16'h0000);
      u_ctl.send(C_DCL, 16'h0000);
      ovl_busy_i <= 1'b0;
      u_ctl.quiet();
      step(3);
      rd_esr(8'h00);
      $display("completion test done");
      u_ctl.send(C_QEN, 16'h0001);
      ques_cond_i <= 16'hffff;
      step(3);
      chk(ques_ena_o, 16'h0001);
      chk(ques_cond_o, 16'h1e2f);
      chk(stb_o[3], 1'b1);
      u_ctl.send(C_QRD, 16'h0000);
      step(0);
      chk(ques_evt_o, 16'h1e2f);
      step(2);
      chk(stb_o[3], 1'b0);
      chk(ques_cond_o, 16'h1e2f);
      u_ctl.send(C_QRD, 16'h0000);
      step(0);
      chk(ques_evt_o, 16'h0000);
      $display("questionable test done");
      // a low enable freezes state, so a strobe in that time is lost
      @(posedge clk_sys_i);
      ce_i <= 1'b0;
      u_ctl.send(C_ESE, 16'h0020);
      step(0);
      chk(ese_o, 8'h00);
      @(posedge clk_sys_i);
      ce_i <= 1'b1;
      $display("clock enable test done");
      u_ctl.send(C_ERR, 16'hff8f);
      mav_i <= 1'b0;
      step(2);
      chk(stb_o[2], 1'b1);
      u_ctl.send(C_CLS, 16'h0000);
      step(2);
      chk(stb_o, 8'h00);
      rd_esr(8'h00);
      $display("clear status test done");
      close_out();
   end
endmodule
